/* File: cdo_audio_out.sv */
// consumer digital audio serialiser: samples in, biphase-mark line out
// assumes sample, error pointer and subcode inputs come from logic on clk_sys
//
// Contract
// - one output carries two 16-bit channels
// - preamble marks block start and channel
// - validity high for erroneous or missing sample, else low
// - user bit carries subcode, one per subframe
// - channel status from upper subcode-q control bits
// - parity bit makes subframe parity even
// - select low means right, high left
// - error pointer flags sample as error data
`timescale 1ns/1ps
module cdo_audio_out
	import cdo_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic [15:0] sample_data,
	input  wire logic        left_right_select,
	input  wire logic        second_stage_error_pointer,
	input  wire logic        sample_valid,
	output logic             sample_ready,
	input  wire logic        subcode_bit,
	input  wire logic        subcode_valid,
	output logic             subcode_take,
	input  wire logic [3:0]  subq_control,
	output logic             audio_out
);
	cdo_state_type  state_reg, state_next;
	logic [4:0]     div_reg, div_next;
	logic [5:0]     half_reg, half_next;
	logic [7:0]     frame_reg, frame_next;
	logic           chan_reg, chan_next;
	logic [7:0]     pre_reg, pre_next;
	logic           pol_reg, pol_next;
	logic           line_reg, line_next;
	logic [CDO_PAYLOAD_W-1:0] data_reg, data_next;
	logic [3:0]     cs_ctrl_reg, cs_ctrl_next;

	cdo_sample_type fifo_in, fifo_head;
	logic           fifo_valid, fifo_pop;
	logic           tick, load, new_chan, new_left, take, cs_bit;
	logic [7:0]     new_frame, new_pre;
	logic [15:0]    smp;
	logic [CDO_PAYLOAD_W-2:0] body;

	// the select level tells which channel each sample belongs to
	assign fifo_in.left = left_right_select;
	assign fifo_in.err  = second_stage_error_pointer;
	assign fifo_in.data = sample_data;

	cdo_fifo #(
		.WIDTH (CDO_SAMPLE_W),
		.DEPTH (CDO_FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.in_data   (fifo_in),
		.in_valid  (sample_valid),
		.in_ready  (sample_ready),
		.out_data  (fifo_head),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	function automatic logic status_bit(input logic [7:0] idx, input logic [3:0] ctrl);
		logic b;
		b = 1'b0;
		if (idx == CDO_CS_DATA) begin
			b = ctrl[2];
		end else if (idx == CDO_CS_COPY) begin
			b = ctrl[1];
		end else if (idx == CDO_CS_EMPH) begin
			b = ctrl[0];
		end else if (idx == CDO_CS_CHAN) begin
			b = ctrl[3];
		end else if (idx == CDO_CS_CATEGORY) begin
			b = 1'b1;
		end
		return b;
	endfunction : status_bit

	assign tick = (div_reg == CDO_TICK_LAST);
	assign load = (state_reg == CDO_START) ||
		((state_reg == CDO_RUN) && tick && (half_reg == CDO_HALF_LAST));

	// subframe about to start: left first, frame advances after right
	always_comb begin
		new_chan  = (state_reg == CDO_START) ? 1'b0 : ~chan_reg;
		new_left  = ~new_chan;
		new_frame = frame_reg;
		if (state_reg == CDO_START) begin
			new_frame = '0;
		end else if (chan_reg) begin
			new_frame = (frame_reg == CDO_FRAME_LAST) ? 8'h00 : frame_reg + 8'h01;
		end
		new_pre = CDO_PRE_RIGHT;
		if (new_left) begin
			new_pre = (new_frame == '0) ? CDO_PRE_BLOCK : CDO_PRE_LEFT;
		end
	end

	// a head of the wrong channel is left in place and the slot sent as invalid,
	// which realigns a stream that started on the right channel
	assign take     = fifo_valid && (fifo_head.left == new_left);
	assign fifo_pop = load && take;
	assign subcode_take = load && subcode_valid;

	always_comb begin
		cs_ctrl_next = cs_ctrl_reg;
		if (load && new_left && (new_frame == '0)) begin
			cs_ctrl_next = subq_control;
		end
		cs_bit = status_bit(new_frame, cs_ctrl_next);
		smp    = take ? fifo_head.data : CDO_MUTE_SAMPLE;
		body   = {cs_bit, (subcode_valid & subcode_bit), (take ? fifo_head.err : 1'b1),
			smp, CDO_AUX_ZERO};
	end

	always_comb begin
		state_next = state_reg;
		div_next   = tick ? '0 : div_reg + 5'h01;
		half_next  = half_reg;
		frame_next = frame_reg;
		chan_next  = chan_reg;
		pre_next   = pre_reg;
		pol_next   = pol_reg;
		line_next  = line_reg;
		data_next  = data_reg;
		case (state_reg)
			CDO_IDLE: begin
				div_next = '0;
				if (fifo_valid) begin
					state_next = CDO_START;
				end
			end
			CDO_START, CDO_RUN: begin
				if (state_reg == CDO_START) begin
					div_next = '0;
				end
				state_next = CDO_RUN;
				if (load) begin
					half_next  = '0;
					frame_next = new_frame;
					chan_next  = new_chan;
					pol_next   = line_reg;
					// preambles break the coding on purpose; polarity follows the line
					line_next  = new_pre[7] ^ line_reg;
					pre_next   = {new_pre[6:0], 1'b0};
					data_next  = {^body, body};
				end else if (tick) begin
					half_next = half_reg + 6'h01;
					if (half_next < CDO_PRE_HALVES) begin
						line_next = pre_reg[7] ^ pol_reg;
						pre_next  = {pre_reg[6:0], 1'b0};
					end else if (!half_next[0]) begin
						line_next = ~line_reg;
					end else begin
						line_next = line_reg ^ data_reg[0];
						data_next = {1'b0, data_reg[CDO_PAYLOAD_W-1:1]};
					end
				end
			end
			default: begin
				state_next = CDO_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg   <= CDO_IDLE;
			div_reg     <= '0;
			half_reg    <= '0;
			frame_reg   <= '0;
			chan_reg    <= 1'b1;
			pre_reg     <= '0;
			pol_reg     <= 1'b0;
			line_reg    <= 1'b0;
			data_reg    <= '0;
			cs_ctrl_reg <= '0;
		end else begin
			state_reg   <= state_next;
			div_reg     <= div_next;
			half_reg    <= half_next;
			frame_reg   <= frame_next;
			chan_reg    <= chan_next;
			pre_reg     <= pre_next;
			pol_reg     <= pol_next;
			line_reg    <= line_next;
			data_reg    <= data_next;
			cs_ctrl_reg <= cs_ctrl_next;
		end
	end

	assign audio_out = line_reg;

	parity_even_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		load |=> (^data_reg == 1'b0))
		else $error("subframe parity not even");

	validity_err_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		fifo_pop |=> (data_reg[CDO_V_POS] == $past(fifo_head.err)))
		else $error("validity bit does not follow error pointer");

	empty_invalid_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(load && !take) |=> data_reg[CDO_V_POS] && (data_reg[CDO_V_POS-1 -: 16] == CDO_MUTE_SAMPLE))
		else $error("missing sample not flagged invalid");

	user_bit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(load && subcode_valid) |=> (data_reg[CDO_U_POS] == $past(subcode_bit)))
		else $error("user bit does not carry subcode");

	status_copy_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(load && new_frame == CDO_CS_COPY) |=> (data_reg[CDO_C_POS] == cs_ctrl_reg[1]))
		else $error("channel status copy bit wrong");

	chan_pop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		fifo_pop |=> (chan_reg == !$past(fifo_head.left)) &&
			(data_reg[CDO_V_POS-1 -: 16] == $past(fifo_head.data)))
		else $error("sample popped into wrong channel slot");

	block_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(load && state_reg == CDO_RUN && chan_reg && frame_reg == CDO_FRAME_LAST)
		|=> (frame_reg == 8'h00) && !chan_reg && (pre_reg == {CDO_PRE_BLOCK[6:0], 1'b0}))
		else $error("block does not restart after frame 191");

	chan_alt_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(load && state_reg == CDO_RUN) |=> (chan_reg != $past(chan_reg)))
		else $error("subframes do not alternate channels");

	cell_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state_reg == CDO_RUN && tick && half_reg[0] && half_reg >= (CDO_PRE_HALVES - 6'h01))
		|=> (line_reg != $past(line_reg)))
		else $error("no transition at bit cell boundary");
endmodule : cdo_audio_out

/* File: cdo_audio_out_bench.sv */
// bench for the cd digital audio output serialiser
// assumes the receiver model decodes every subframe on the line
`timescale 1ns/1ps
`define CHK(nm, gt, ex) begin n_checks++; if ((gt) !== (ex)) begin n_mismatch++; \
	$display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module cdo_audio_out_bench import cdo_pkg::*;;
	localparam logic [31:0] U_PAT   = 32'hb5c3_6e19;
	localparam int          N_WORDS = 24;
	localparam int          N_SLOTS = 28;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic [15:0] sample_data = 16'h0000;
	logic        left_right_select = 1'b0;
	logic        second_stage_error_pointer = 1'b0;
	logic        sample_valid = 1'b0;
	logic        sample_ready;
	logic        subcode_bit = 1'b0;
	logic        subcode_valid = 1'b1;
	logic        subcode_take;
	logic [3:0]  subq_control = 4'hd;
	logic        audio_out;
	logic [7:0]  rx_pre;
	logic [27:0] rx_bits;
	logic        rx_bad;
	int          rx_count;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          u_idx = 0;
	always #5 clk_sys = ~clk_sys;
	cdo_audio_out i_dut (
		.clk_sys                    (clk_sys),
		.sys_rst                    (sys_rst),
		.sample_data                (sample_data),
		.left_right_select          (left_right_select),
		.second_stage_error_pointer (second_stage_error_pointer),
		.sample_valid               (sample_valid),
		.sample_ready               (sample_ready),
		.subcode_bit                (subcode_bit),
		.subcode_valid              (subcode_valid),
		.subcode_take               (subcode_take),
		.subq_control               (subq_control),
		.audio_out                  (audio_out)
	);
	cdo_receiver i_rx (.clk_sys(clk_sys), .line(audio_out), .pre(rx_pre), .bits(rx_bits),
		.bad(rx_bad), .count(rx_count));
	// subcode source stops offering after 26 bits so idle user bits show too
	always @(posedge clk_sys) if (subcode_take === 1'b1) u_idx++;
	always @(negedge clk_sys) begin
		subcode_bit <= U_PAT[u_idx[4:0]];
		subcode_valid <= (u_idx < 26);
	end
	// word 5 repeats the left channel to force one misaligned slot
	function automatic cdo_sample_type word(input int i);
		word.left = (i < 5) ? ~i[0] : i[0];
		word.err = (i % 7 == 3);
		word.data = 16'(16'h9e37 * (i + 1));
	endfunction : word
	function automatic logic cs_bit(input int f);
		case (f)
			1: cs_bit = subq_control[2];
			2: cs_bit = subq_control[1];
			3: cs_bit = subq_control[0];
			5: cs_bit = subq_control[3];
			8: cs_bit = 1'b1;
			default: cs_bit = 1'b0;
		endcase
	endfunction : cs_bit
	task automatic push_word(input int i);
		int w;
		w = 0;
		{left_right_select, second_stage_error_pointer, sample_data} = word(i);
		sample_valid = 1'b1;
		while (sample_ready !== 1'b1 && w < 5000) begin
			@(negedge clk_sys);
			w++;
		end
		if (w >= 5000) n_mismatch++;
		@(negedge clk_sys);
	endtask : push_word
	task automatic check_idle();
		repeat (20) @(negedge clk_sys);
		`CHK("line idle", audio_out, 1'b0)
		`CHK("ready after reset", sample_ready, 1'b1)
		`CHK("take idle", subcode_take, 1'b0)
	endtask : check_idle
	// one pop happens at the first load, so 17 words fit before refusal
	task automatic send_words();
		for (int i = 0; i < N_WORDS; i++) begin
			if (i < 17) `CHK("ready while filling", sample_ready, 1'b1)
			push_word(i);
			if (i == 16) `CHK("ready when full", sample_ready, 1'b0)
		end
		sample_valid = 1'b0;
	endtask : send_words
	task automatic check_line();
		int k;
		int w;
		cdo_sample_type e;
		logic [27:0] b;
		logic [7:0]  p;
		k = 0;
		for (int s = 0; s < N_SLOTS; s++) begin
			w = 0;
			while (rx_count <= s && w < 3000) begin
				@(negedge clk_sys);
				w++;
			end
			if (w >= 3000) n_mismatch++;
			e = (k < N_WORDS) ? word(k) : {1'b0, 1'b1, CDO_MUTE_SAMPLE};
			if (k < N_WORDS && e.left === ~s[0]) k++;
			else e = {1'b0, 1'b1, CDO_MUTE_SAMPLE};
			b = rx_bits;
			p = (s == 0) ? CDO_PRE_BLOCK : (s[0] ? CDO_PRE_RIGHT : CDO_PRE_LEFT);
			`CHK("preamble", rx_pre, p)
			`CHK("cell transitions", rx_bad, 1'b0)
			`CHK("aux bits", b[7:0], CDO_AUX_ZERO)
			`CHK("sample", b[23:8], e.data)
			`CHK("validity", b[CDO_V_POS], e.err)
			`CHK("user bit", b[CDO_U_POS], (s < 26) ? U_PAT[s] : 1'b0)
			`CHK("status bit", b[CDO_C_POS], cs_bit(s / 2))
			`CHK("parity", ^b, 1'b0)
		end
	endtask : check_line
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (5) @(negedge clk_sys);
		sys_rst = 1'b0;
		check_idle();
		fork
			send_words();
			check_line();
		join
		complete_run();
	end
	// 28 subframes of about 1088 clocks each, with ample margin
	initial begin
		repeat (60000) @(posedge clk_sys);
		n_mismatch++;
		complete_run();
	end
endmodule : cdo_audio_out_bench

/* File: cdo_fifo.sv */
// parameterised valid/ready fifo for the audio sample path
// assumes both sides run on clk_sys
`timescale 1ns/1ps
module cdo_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
	localparam logic [AW:0] ONE_COUNT  = (AW+1)'(1);
	localparam logic [AW-1:0] ONE_PTR  = AW'(1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [AW:0]      count_reg, count_next;
	logic             push, pop;

	assign in_ready  = (count_reg != FULL_COUNT);
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wr_ptr_next = push ? wr_ptr_reg + ONE_PTR : wr_ptr_reg;
		rd_ptr_next = pop ? rd_ptr_reg + ONE_PTR : rd_ptr_reg;
		count_next  = count_reg;
		if (push && !pop) begin
			count_next = count_reg + ONE_COUNT;
		end else if (pop && !push) begin
			count_next = count_reg - ONE_COUNT;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end
endmodule : cdo_fifo

/* File: cdo_pkg.sv */
// constants and types for the cd digital audio output serialiser
// assumes a single 100 MHz system clock and a 44.1 kHz sample stream
package cdo_pkg;
	localparam int         CDO_CLK_HZ           = 100_000_000;
	localparam int         CDO_FS_HZ            = 44_100;
	localparam int         CDO_HALVES_PER_FRAME = 128;
	// longest period rounds down so the line never runs slower than the source
	localparam int         CDO_TICK_DIV         = CDO_CLK_HZ / (CDO_FS_HZ * CDO_HALVES_PER_FRAME);
	localparam logic [4:0] CDO_TICK_LAST        = 5'(CDO_TICK_DIV - 1);
	localparam logic [5:0] CDO_HALF_LAST        = 6'h3f;
	localparam logic [5:0] CDO_PRE_HALVES       = 6'h08;
	localparam logic [7:0] CDO_FRAME_LAST       = 8'hbf;
	localparam logic [7:0] CDO_PRE_BLOCK        = 8'he8;
	localparam logic [7:0] CDO_PRE_LEFT         = 8'he2;
	localparam logic [7:0] CDO_PRE_RIGHT        = 8'he4;
	localparam int         CDO_PAYLOAD_W        = 28;
	localparam int         CDO_V_POS            = 24;
	localparam int         CDO_U_POS            = 25;
	localparam int         CDO_C_POS            = 26;
	localparam int         CDO_P_POS            = 27;
	localparam logic [7:0] CDO_AUX_ZERO         = 8'h00;
	localparam logic [15:0] CDO_MUTE_SAMPLE     = 16'h0000;
	localparam logic [7:0] CDO_CS_DATA          = 8'h01;
	localparam logic [7:0] CDO_CS_COPY          = 8'h02;
	localparam logic [7:0] CDO_CS_EMPH          = 8'h03;
	localparam logic [7:0] CDO_CS_CHAN          = 8'h05;
	localparam logic [7:0] CDO_CS_CATEGORY      = 8'h08;
	localparam int         CDO_FIFO_DEPTH       = 16;

	typedef struct packed {
		logic        left;
		logic        err;
		logic [15:0] data;
	} cdo_sample_type;

	localparam int CDO_SAMPLE_W = $bits(cdo_sample_type);

	typedef enum logic [1:0] {
		CDO_IDLE  = 2'b00,
		CDO_START = 2'b01,
		CDO_RUN   = 2'b11
	} cdo_state_type;
endpackage : cdo_pkg

/* File: cdo_receiver.sv */
// partner model: consumer audio receiver decoding the biphase-mark line
// assumes the line idles low and each half-cell lasts CDO_TICK_DIV clocks
`timescale 1ns/1ps
module cdo_receiver
	import cdo_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        line,
	output logic      [7:0]  pre,
	output logic      [27:0] bits,
	output logic             bad,
	output int               count
);
	logic [0:63] h;
	logic        prev;
	initial begin
		count = 0;
		pre = 8'h00;
		bits = 28'h0000000;
		bad = 1'b0;
		prev = 1'b0;
		// first rise opens the first preamble; then sample mid half-cell
		@(posedge clk_sys iff line === 1'b1);
		repeat (8) @(posedge clk_sys);
		forever begin
			for (int i = 0; i < 64; i++) begin
				h[i] = line;
				repeat (CDO_TICK_DIV) @(posedge clk_sys);
			end
			// preamble polarity follows the previous level, so normalise it
			bad = (h[0] === prev);
			pre = h[0] ? h[0:7] : ~h[0:7];
			for (int k = 0; k < 28; k++) begin
				bits[k] = h[8+2*k] ^ h[9+2*k];
				if (h[8+2*k] === h[7+2*k]) bad = 1'b1;
			end
			prev = h[63];
			count++;
		end
	end
endmodule : cdo_receiver
